// ===== rtl/smart_card_defines.vh
// Constants for the smart card serial control block
`ifndef SMART_CARD_DEFINES_VH
`define SMART_CARD_DEFINES_VH
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_FLUSH       12'h008
`define BIT_IFACE_ON    0
`define BIT_NACK_SUP    1
`define BIT_PROTOCOL    2
`define RETRY_LSB       4
`define RETRY_MSB       6
`define GUARD_LSB       8
`define GUARD_MSB       15
`define CTRL_RESET      32'h0000_0000
`define NOMINAL_GUARD   8'h02
`define GUARD_ONE_BIT   8'hff
`define GUARD_SINGLE    9'h001
`define CLR_ERR_BIT     1
`define ST_CNT_LSB      0
`define ST_CNT_MSB      1
`define ST_ERR_BIT      2
`define ST_LOCK_BIT     3
`define STATUS_RESET    32'h0000_0000
`define READ_ZERO       32'h0000_0000
`define RETRY_CLEAR     3'h0
`define RETRY_STEP      3'h1
`endif

// ===== rtl/smart_card_serial_control.v
// Smart card control register, retry counter, guard timing and lock logic
`timescale 1ns/1ps
`include "smart_card_defines.vh"
module smart_card_serial_control (
  input  wire        pclk,             // Bus clock, 40 MHz
  input  wire        presetn,          // Async reset, active low
  input  wire        psel,             // APB select
  input  wire        penable,          // APB enable
  input  wire        pwrite,           // APB direction
  input  wire [11:0] paddr,            // APB byte address
  input  wire [31:0] pwdata,           // APB write data
  output reg  [31:0] prdata,           // APB read data
  output reg         pready,           // APB ready
  output reg         pslverr,          // APB error
  input  wire        char_done,        // Serial core: character sent, pulse
  input  wire        nack_seen,        // Serial core: card NACK seen, pulse
  input  wire        tx_err_irq_en,    // Interrupt enable for transmit error
  output reg         card_mode_q,      // Half-duplex smart card mode active
  output reg         nack_drive_q,     // Core may issue NACK on receive errors
  output reg         resend_q,         // Pulse: retransmit last character
  output reg         tx_error_q,       // Transmit error flag in line status
  output reg         tx_irq_q,         // Interrupt request, level
  output reg         locked_q,         // Transmitter locked until flush
  output reg  [8:0]  guard_bits_q      // Guard time in bit times after a character
);

  // Retry sequencer states, one-hot
  localparam [2:0] ST_READY  = 3'b001;  // No NACK pending, count at zero
  localparam [2:0] ST_RETRY  = 3'b010;  // Resending after at least one NACK
  localparam [2:0] ST_LOCKED = 3'b100;  // Gave up, waits for a flush

  // Registers and their next values
  reg  [31:0] ctrl_q;
  reg  [31:0] ctrl_d;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [2:0]  retry_cnt_q;
  reg  [2:0]  retry_cnt_d;
  reg         resend_d;
  reg         tx_error_d;
  reg         tx_irq_d;
  reg  [31:0] status_word;
  reg  [31:0] rdata_d;
  reg  [8:0]  guard_bits_d;

  // Decoded fields and bus qualifiers
  wire        iface_on;
  wire        nack_suppress;
  wire        t0;
  wire [2:0]  resend_limit;
  wire [7:0]  added_guard_units;
  wire        setup;
  wire        access;
  wire        sel_ctrl;
  wire        sel_status;
  wire        sel_flush;
  wire        mapped;
  wire        wr;
  wire        rd;
  wire        wr_ctrl;
  wire        clr_err;
  wire        flush;
  wire        nack_t0;
  wire        at_limit;
  wire        give_up;

  // Control fields
  assign iface_on          = ctrl_q[`BIT_IFACE_ON];
  assign nack_suppress     = ctrl_q[`BIT_NACK_SUP];
  assign t0                = ~ctrl_q[`BIT_PROTOCOL];
  assign resend_limit      = ctrl_q[`RETRY_MSB:`RETRY_LSB];
  assign added_guard_units = ctrl_q[`GUARD_MSB:`GUARD_LSB];

  // Read data prepared in setup, writes land in the access phase
  assign setup      = psel & ~penable;
  assign access     = psel & penable & pready;
  assign sel_ctrl   = (paddr == `OFS_CTRL);
  assign sel_status = (paddr == `OFS_STATUS);
  assign sel_flush  = (paddr == `OFS_FLUSH);
  assign mapped     = sel_ctrl | sel_status | sel_flush;
  assign wr         = access & pwrite;
  assign rd         = setup & ~pwrite;
  assign wr_ctrl    = wr & sel_ctrl;
  assign clr_err    = wr & sel_status & pwdata[`CLR_ERR_BIT];
  assign flush      = wr & sel_flush;

  // NACKs count only in smart card mode under T=0
  assign nack_t0  = iface_on & t0 & nack_seen;
  assign at_limit = (retry_cnt_q == resend_limit);
  assign give_up  = nack_t0 & (state_q != ST_LOCKED) & at_limit;

  // Control register; reserved bits stay zero
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d                        = `CTRL_RESET;
      ctrl_d[`BIT_IFACE_ON]         = pwdata[`BIT_IFACE_ON];
      ctrl_d[`BIT_NACK_SUP]         = pwdata[`BIT_NACK_SUP];
      ctrl_d[`BIT_PROTOCOL]         = pwdata[`BIT_PROTOCOL];
      ctrl_d[`RETRY_MSB:`RETRY_LSB] = pwdata[`RETRY_MSB:`RETRY_LSB];
      ctrl_d[`GUARD_MSB:`GUARD_LSB] = pwdata[`GUARD_MSB:`GUARD_LSB];
    end
  end

  // Retry sequencer: resends until NACK count passes the limit
  always @* begin
    state_d     = state_q;
    retry_cnt_d = retry_cnt_q;
    resend_d    = 1'b0;
    case (state_q)
      ST_READY: begin
        if (give_up) begin
          state_d = ST_LOCKED;
        end else if (nack_t0 && !flush) begin
          state_d     = ST_RETRY;
          retry_cnt_d = retry_cnt_q + `RETRY_STEP;
          resend_d    = 1'b1;
        end
      end
      ST_RETRY: begin
        if (give_up) begin
          state_d     = ST_LOCKED;
          retry_cnt_d = `RETRY_CLEAR;
        end else if (flush) begin
          state_d     = ST_READY;
          retry_cnt_d = `RETRY_CLEAR;
        end else if (nack_t0) begin
          retry_cnt_d = retry_cnt_q + `RETRY_STEP;
          resend_d    = 1'b1;
        end else if (char_done) begin
          state_d     = ST_READY;
          retry_cnt_d = `RETRY_CLEAR;
        end
      end
      ST_LOCKED: begin
        if (flush) begin
          state_d     = ST_READY;
          retry_cnt_d = `RETRY_CLEAR;
        end
      end
      default: begin
        state_d     = ST_READY;
        retry_cnt_d = `RETRY_CLEAR;
      end
    endcase
  end

  // Error flag and interrupt; a give-up beats a clear in the same cycle
  always @* begin
    tx_error_d = tx_error_q;
    tx_irq_d   = tx_irq_q;
    if (clr_err) begin
      tx_error_d = 1'b0;
      tx_irq_d   = 1'b0;
    end
    if (give_up) begin
      tx_error_d = 1'b1;
      tx_irq_d   = (tx_irq_q & ~clr_err) | tx_err_irq_en;
    end
  end

  // Status word: count, error flag and lock
  always @* begin
    status_word                          = `STATUS_RESET;
    status_word[`ST_CNT_MSB:`ST_CNT_LSB] = retry_cnt_q[`ST_CNT_MSB-`ST_CNT_LSB:0];
    status_word[`ST_ERR_BIT]             = tx_error_q;
    status_word[`ST_LOCK_BIT]            = locked_q;
  end

  // Read data chosen in setup so it stands through the access phase
  always @* begin
    rdata_d = prdata;
    if (rd) begin
      if (sel_ctrl) begin
        rdata_d = ctrl_q;
      end else if (sel_status) begin
        rdata_d = status_word;
      end else begin
        rdata_d = `READ_ZERO;
      end
    end
  end

  // Guard time in bit times; T=1 keeps the nominal two
  always @* begin
    if (!t0) begin
      guard_bits_d = {1'b0, `NOMINAL_GUARD};
    end else if (added_guard_units == `GUARD_ONE_BIT) begin
      guard_bits_d = `GUARD_SINGLE;
    end else begin
      guard_bits_d = {1'b0, added_guard_units} + {1'b0, `NOMINAL_GUARD};
    end
  end

  // Bus answer: access phase follows every setup with no wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `READ_ZERO;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= rdata_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= ST_READY;
      retry_cnt_q <= `RETRY_CLEAR;
      resend_q    <= 1'b0;
      locked_q    <= 1'b0;
    end else begin
      state_q     <= state_d;
      retry_cnt_q <= retry_cnt_d;
      resend_q    <= resend_d;
      locked_q    <= (state_d == ST_LOCKED);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_error_q <= 1'b0;
      tx_irq_q   <= 1'b0;
    end else begin
      tx_error_q <= tx_error_d;
      tx_irq_q   <= tx_irq_d;
    end
  end

  // Mode outputs and guard time
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_mode_q  <= 1'b0;
      nack_drive_q <= 1'b0;
      guard_bits_q <= {1'b0, `NOMINAL_GUARD};
    end else begin
      card_mode_q  <= iface_on;
      nack_drive_q <= iface_on & t0 & ~nack_suppress;
      guard_bits_q <= guard_bits_d;
    end
  end
endmodule

// ===== verif/smart_card_props.sv
// Assertions on the smart card control ports
`timescale 1ns/1ps
module smart_card_props (
  input wire        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire        nack_seen, tx_err_irq_en, card_mode_q, nack_drive_q,
  input wire        resend_q, tx_error_q, tx_irq_q, locked_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_bad; s_setup ##0 !(paddr inside {12'h000, 12'h004, 12'h008}); endsequence
  AST_READY: assert property (s_setup |=> pready) else $error("no ready");
  AST_REFUSE: assert property (s_bad |=> pslverr) else $error("no slave error");
  AST_MODE: assert property ($changed(card_mode_q) |->
    $past(pready && pwrite && paddr == 12'h000, 2)) else $error("mode changed without write");
  AST_NACK: assert property (nack_drive_q |-> card_mode_q) else $error("nack outside mode");
  AST_RESEND: assert property (resend_q |-> $past(nack_seen && !locked_q))
    else $error("resend without nack");
  AST_LOCK: assert property ($rose(locked_q) |-> tx_error_q && $past(nack_seen))
    else $error("bad lock");
  AST_IRQ: assert property ($rose(tx_irq_q) |-> tx_error_q && $past(tx_err_irq_en))
    else $error("bad irq");
  AST_HOLD: assert property (locked_q && nack_seen |=> !resend_q) else $error("resend when locked");
endmodule

// ===== verif/card_model.sv
// Card side: accepts or rejects each character sent
`timescale 1ns/1ps
module card_model (
  input  wire pclk,      // Clock
  input  wire send,      // Character sent
  input  wire reject,    // Card rejects
  output reg  char_done, // Accepted
  output reg  nack_seen  // Line pulled low in guard time
);
  initial {char_done, nack_seen} = 2'b00;
  always @(posedge pclk) begin
    char_done <= send && !reject;
    nack_seen <= send && reject;
  end
endmodule

// ===== verif/smart_card_serial_control_tb.sv
// Testbench for the smart card control block
`timescale 1ns/1ps
module smart_card_serial_control_tb;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg         go = 0, rej = 0, tx_err_irq_en = 0;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0, v, exp_q[$];
  wire [31:0] prdata;
  wire [8:0]  guard_bits_q;
  wire        pready, pslverr, char_done, nack_seen, card_mode_q, nack_drive_q;
  wire        resend_q, tx_error_q, tx_irq_q, locked_q;
  integer     seed = 32'h7611ecbf, err_count = 0, comparisons = 0, n_rs = 0, i;
  smart_card_serial_control u_smart_card_serial_control (.*);
  card_model u_card_model (.pclk(pclk), .send(go | resend_q), .reject(rej),
    .char_done(char_done), .nack_seen(nack_seen));
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (resend_q) n_rs <= n_rs + 1;
  always @(posedge pclk) if (pready && !pwrite) chk(prdata, exp_q.pop_front());
  task chk(input [31:0] s, input [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task ap(input w, input [11:0] a, input [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk) while (!pready) @(posedge pclk);
    chk(pslverr, a != 12'h000 && a != 12'h004 && a != 12'h008);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rd(input [11:0] a, input [31:0] e);
    exp_q.push_back(e);
    ap(0, a, 0);
  endtask
  task tally_and_finish;
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(12'h000, 0);
    rd(12'h00c, 0);
    for (i = 0; i < 6; i++) begin
      v = $random(seed) & 32'h0000ff77;
      if (i == 0) v = 32'h0000ff01;
      ap(1, 0, v);
      rd(0, v);
      chk(card_mode_q, v[0]);
      chk(nack_drive_q, v[0] & !v[1] & !v[2]);
      chk(guard_bits_q, v[2] ? 2 : v[15:8] == 8'hff ? 1 : v[15:8] + 2);
    end
    ap(1, 12'h00c, 32'hffff);
    rd(0, v);
    tx_err_irq_en <= 1;
    ap(1, 0, 32'h21);
    rej <= 1; go <= 1;
    @(posedge pclk) go <= 0;
    for (i = 0; i < 50 && locked_q !== 1'b1; i++) @(posedge pclk);
    rd(12'h004, 32'hc);
    go <= 1;
    @(posedge pclk) go <= 0;
    repeat (3) @(posedge pclk);
    chk(n_rs, 2);
    chk({tx_error_q, tx_irq_q, locked_q}, 3'b111);
    ap(1, 12'h008, 0);
    ap(1, 12'h004, 2);
    rd(12'h004, 0);
    chk({tx_error_q, tx_irq_q, locked_q}, 3'b000);
    ap(1, 0, 32'h11);
    rej <= 1; go <= 1;
    @(posedge pclk) go <= 0;
    rej <= 0;
    repeat (4) @(posedge pclk);
    rd(12'h004, 0);
    chk(n_rs, 3);
    tx_err_irq_en <= 0;
    ap(1, 0, 32'h01);
    rej <= 1; go <= 1;
    @(posedge pclk) go <= 0;
    repeat (3) @(posedge pclk);
    chk({tx_error_q, tx_irq_q, locked_q}, 3'b101);
    chk(n_rs, 3);
    tally_and_finish;
  end
  initial begin
    #200000;
    err_count++;
    tally_and_finish;
  end
endmodule
bind smart_card_serial_control smart_card_props u_smart_card_props (.*);
